// ===== include/pqs_defines.vh
`ifndef PQS_DEFINES_VH
`define PQS_DEFINES_VH
// register byte offsets
`define PQS_OFS_Q_PIN_INPUT     12'h000
`define PQS_OFS_Q_DIRECTION     12'h004
`define PQS_OFS_Q_DRIVE_REDUCE  12'h008
`define PQS_OFS_Q_PULL_ENABLE   12'h00C
`define PQS_OFS_Q_PULL_POLARITY 12'h010
`define PQS_OFS_S_DATA          12'h014
`define PQS_OFS_S_PIN_INPUT     12'h018
`define PQS_OFS_S_DIRECTION     12'h01C
`define PQS_OFS_S_DRIVE_REDUCE  12'h020
`define PQS_OFS_S_PULL_ENABLE   12'h024
`define PQS_OFS_S_PULL_POLARITY 12'h028
`define PQS_OFS_S_OPEN_DRAIN    12'h02C
`define PQS_OFS_FUNC_ENABLE     12'h030
// implemented port Q bits, reset value
`define PQS_Q_MASK              8'h7F
`define PQS_RST8                8'h00
// port S direction bits that steer a pin, pin counts
`define PQS_S_DIR_MASK          8'hF7
`define PQS_Q_PINS              7
`define PQS_S_PINS              8
// function enable register fields
`define PQS_FE_SPI              0
`define PQS_FE_S1_TX            1
`define PQS_FE_S1_RX            2
`define PQS_FE_S0_TX            3
`define PQS_FE_S0_RX            4
`define PQS_FE_FAULT_LO         8
`define PQS_FE_FAULT_HI         14
`define PQS_FE_MASK             32'h00007F1F
`endif

// ===== hw/pqs_port_qs.v
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "pqs_defines.vh"
module pqs_port_qs (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // port q pad
  input  wire [6:0]  portQIn,
  output reg  [6:0]  portQOut,
  output reg  [6:0]  portQOe,
  output reg  [6:0]  portQReduce,
  output reg  [6:0]  portQPullUp,
  output reg  [6:0]  portQPullDown,
  // port s pad
  input  wire [7:0]  portSIn,
  output reg  [7:0]  portSOut,
  output reg  [7:0]  portSOe,
  output reg  [7:0]  portSReduce,
  output reg  [7:0]  portSPullUp,
  output reg  [7:0]  portSPullDown,
  // motor pwm fault module inputs
  output reg  [3:0]  pwmFault,
  output reg  [2:0]  pwmCurrentSenseN,
  // spi peripheral side, order ss, sck, mosi, miso
  input  wire [3:0]  spiOut,
  input  wire [3:0]  spiOe,
  output reg  [3:0]  spiIn,
  // serial channels
  input  wire        secondSerialTransmit,
  output reg         secondSerialReceive,
  input  wire        firstSerialTransmit,
  output reg         firstSerialReceive
);

////////////////////////////////////////////////////////////////////////////

reg  [6:0]  qSync1_q, qSync2_q, qSync3_q, qPin_q;
reg  [7:0]  sSync1_q, sSync2_q, sSync3_q, sPin_q;
reg  [6:0]  qDir_q, qDrv_q, qPe_q, qPol_q;
reg  [7:0]  sData_q, sDir_q, sDrv_q, sPe_q, sPol_q, sOd_q;
reg  [31:0] funcEn_q;
reg  [31:0] rdata_d;
reg  [6:0]  qOe_d;
reg  [7:0]  sOe_d, sOut_d, sPullOk_d;
reg         hit_d;
wire        wrEn;
wire        rdEn;
wire [6:0]  qFuncEn;
wire [7:0]  wb;
wire [7:0]  sDirEff;
// one select per writable register; input registers have none
wire        selQDir;
wire        selQDrv;
wire        selQPe;
wire        selQPol;
wire        selSData;
wire        selSDir;
wire        selSDrv;
wire        selSPe;
wire        selSPol;
wire        selSOd;
wire        selFunc;
// loop indices, one per process
integer     i;
integer     j;
integer     k;
integer     n;
integer     p;

assign wrEn    = psel & penable & pwrite;
assign rdEn    = psel & ~penable & ~pwrite;
assign qFuncEn = funcEn_q[`PQS_FE_FAULT_HI:`PQS_FE_FAULT_LO];
assign wb      = pwdata[7:0];
// pin 3 direction bit is stored but never steers the pin
assign sDirEff = sDir_q & `PQS_S_DIR_MASK;

// address decode shared by the write processes
assign selQDir  = addrIs(paddr, `PQS_OFS_Q_DIRECTION);
assign selQDrv  = addrIs(paddr, `PQS_OFS_Q_DRIVE_REDUCE);
assign selQPe   = addrIs(paddr, `PQS_OFS_Q_PULL_ENABLE);
assign selQPol  = addrIs(paddr, `PQS_OFS_Q_PULL_POLARITY);
assign selSData = addrIs(paddr, `PQS_OFS_S_DATA);
assign selSDir  = addrIs(paddr, `PQS_OFS_S_DIRECTION);
assign selSDrv  = addrIs(paddr, `PQS_OFS_S_DRIVE_REDUCE);
assign selSPe   = addrIs(paddr, `PQS_OFS_S_PULL_ENABLE);
assign selSPol  = addrIs(paddr, `PQS_OFS_S_PULL_POLARITY);
assign selSOd   = addrIs(paddr, `PQS_OFS_S_OPEN_DRAIN);
assign selFunc  = addrIs(paddr, `PQS_OFS_FUNC_ENABLE);

// register select: full byte address match
function addrIs;
  input [11:0] a;
  input [11:0] ofs;
  begin
    addrIs = (a == ofs);
  end
endfunction

// pull device per pin: up on polarity 0, down on 1
function [1:0] pullSel;
  input en;
  input pol;
  begin
    pullSel = {en & pol, en & ~pol};
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers, change accepted when stages two and three agree
// a glitch shorter than one clock never reaches the pin registers

// port Q pins
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    qSync1_q <= 7'h00;
    qSync2_q <= 7'h00;
    qSync3_q <= 7'h00;
    qPin_q   <= 7'h00;
  end else begin
    qSync1_q <= portQIn;
    qSync2_q <= qSync1_q;
    qSync3_q <= qSync2_q;
    for (i = 0; i < `PQS_Q_PINS; i = i + 1) begin
      if (qSync2_q[i] == qSync3_q[i])
        qPin_q[i] <= qSync3_q[i];
    end
  end
end

// port S pins
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    sSync1_q <= 8'h00;
    sSync2_q <= 8'h00;
    sSync3_q <= 8'h00;
    sPin_q   <= 8'h00;
  end else begin
    sSync1_q <= portSIn;
    sSync2_q <= sSync1_q;
    sSync3_q <= sSync2_q;
    for (j = 0; j < `PQS_S_PINS; j = j + 1) begin
      if (sSync2_q[j] == sSync3_q[j])
        sPin_q[j] <= sSync3_q[j];
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// register writes, taken in the access phase

// port Q configuration, bit 7 has no storage
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    qDir_q <= 7'h00;
    qDrv_q <= 7'h00;
    qPe_q  <= 7'h00;
    qPol_q <= 7'h00;
  end else if (wrEn) begin
    if (selQDir)
      qDir_q <= wb[6:0];
    if (selQDrv)
      qDrv_q <= wb[6:0];
    if (selQPe)
      qPe_q <= wb[6:0];
    if (selQPol)
      qPol_q <= wb[6:0];
  end
end

////////////////////////////////////////////////////////////////////////////
// port S configuration and data latch

always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    sData_q <= `PQS_RST8;
    sDir_q  <= `PQS_RST8;
    sDrv_q  <= `PQS_RST8;
    sPe_q   <= `PQS_RST8;
    sPol_q  <= `PQS_RST8;
    sOd_q   <= `PQS_RST8;
  end else if (wrEn) begin
    if (selSData)
      sData_q <= wb;
    if (selSDir)
      sDir_q <= wb;
    if (selSDrv)
      sDrv_q <= wb;
    if (selSPe)
      sPe_q <= wb;
    if (selSPol)
      sPol_q <= wb;
    if (selSOd)
      sOd_q <= wb;
  end
end

////////////////////////////////////////////////////////////////////////////
// function enables, stand-in for the peripherals' own enable bits

always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n)
    funcEn_q <= 32'h00000000;
  else if (wrEn & selFunc)
    funcEn_q <= pwdata & `PQS_FE_MASK;
end

////////////////////////////////////////////////////////////////////////////
// read mux and decode

always @* begin
  hit_d   = 1'b1;
  rdata_d = 32'h00000000;
  case (paddr)
    `PQS_OFS_Q_PIN_INPUT:     rdata_d[6:0] = qPin_q;
    `PQS_OFS_Q_DIRECTION:     rdata_d[6:0] = qDir_q;
    `PQS_OFS_Q_DRIVE_REDUCE:  rdata_d[6:0] = qDrv_q;
    `PQS_OFS_Q_PULL_ENABLE:   rdata_d[6:0] = qPe_q;
    `PQS_OFS_Q_PULL_POLARITY: rdata_d[6:0] = qPol_q;
    `PQS_OFS_S_DATA:
      rdata_d[7:0] = (sDirEff & sData_q) | (~sDirEff & sPin_q);
    `PQS_OFS_S_PIN_INPUT:     rdata_d[7:0] = sPin_q;
    `PQS_OFS_S_DIRECTION:     rdata_d[7:0] = sDirEff;
    `PQS_OFS_S_DRIVE_REDUCE:  rdata_d[7:0] = sDrv_q;
    `PQS_OFS_S_PULL_ENABLE:   rdata_d[7:0] = sPe_q;
    `PQS_OFS_S_PULL_POLARITY: rdata_d[7:0] = sPol_q;
    `PQS_OFS_S_OPEN_DRAIN:    rdata_d[7:0] = sOd_q;
    `PQS_OFS_FUNC_ENABLE:     rdata_d      = funcEn_q;
    default:                  hit_d        = 1'b0;
  endcase
end

// zero-wait slave: pready high in every access phase
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    prdata  <= 32'h00000000;
    pready  <= 1'b0;
    pslverr <= 1'b0;
  end else begin
    pready  <= psel & ~penable;
    pslverr <= psel & ~penable & ~hit_d;
    if (rdEn)
      prdata <= rdata_d;
  end
end

////////////////////////////////////////////////////////////////////////////
// pin ownership and direction

always @* begin
  for (k = 0; k < `PQS_Q_PINS; k = k + 1)
    qOe_d[k] = qDir_q[k] & ~qFuncEn[k];
  // port S: registers first, peripherals then override
  sOe_d  = sDirEff;
  sOut_d = sData_q;
  if (funcEn_q[`PQS_FE_SPI]) begin
    sOe_d[7:4]  = spiOe;
    sOut_d[7:4] = spiOut;
  end
  if (funcEn_q[`PQS_FE_S1_TX]) begin
    sOe_d[3]  = 1'b1;
    sOut_d[3] = secondSerialTransmit;
  end
  if (funcEn_q[`PQS_FE_S1_RX])
    sOe_d[2] = 1'b0;
  if (funcEn_q[`PQS_FE_S0_TX]) begin
    sOe_d[1]  = 1'b1;
    sOut_d[1] = firstSerialTransmit;
  end
  if (funcEn_q[`PQS_FE_S0_RX])
    sOe_d[0] = 1'b0;
  // open drain: release the pin instead of driving it high
  for (k = 0; k < `PQS_S_PINS; k = k + 1) begin
    if (sOd_q[k] & sOut_d[k])
      sOe_d[k] = 1'b0;
    sPullOk_d[k] = ~sOe_d[k] | sOd_q[k];
  end
end

////////////////////////////////////////////////////////////////////////////
// registered pad controls; reset leaves every pin an undriven input

// port Q pads: no data latch here, so never driven high
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    portQOut      <= 7'h00;
    portQOe       <= 7'h00;
    portQReduce   <= 7'h00;
    portQPullUp   <= 7'h00;
    portQPullDown <= 7'h00;
  end else begin
    portQOut    <= 7'h00;
    portQOe     <= qOe_d;
    portQReduce <= qDrv_q & qOe_d;
    for (n = 0; n < `PQS_Q_PINS; n = n + 1)
      {portQPullDown[n], portQPullUp[n]} <=
        pullSel(qPe_q[n] & ~qOe_d[n], qPol_q[n]);
  end
end

// port S pads
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    portSOut      <= 8'h00;
    portSOe       <= 8'h00;
    portSReduce   <= 8'h00;
    portSPullUp   <= 8'h00;
    portSPullDown <= 8'h00;
  end else begin
    portSOut    <= sOut_d & ~sOd_q;
    portSOe     <= sOe_d;
    portSReduce <= sDrv_q & sOe_d;
    for (p = 0; p < `PQS_S_PINS; p = p + 1)
      {portSPullDown[p], portSPullUp[p]} <=
        pullSel(sPe_q[p] & sPullOk_d[p], sPol_q[p]);
  end
end

// synchronised pin levels handed to the peripherals
always @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    pwmFault            <= 4'h0;
    pwmCurrentSenseN    <= 3'h7;
    spiIn               <= 4'h0;
    secondSerialReceive <= 1'b1;
    firstSerialReceive  <= 1'b1;
  end else begin
    pwmFault            <= qPin_q[3:0];
    pwmCurrentSenseN    <= qPin_q[6:4];
    spiIn               <= sPin_q[7:4];
    secondSerialReceive <= sPin_q[2];
    firstSerialReceive  <= sPin_q[0];
  end
end

endmodule

// ===== verification/pqs_port_qs_chk.sv
`timescale 1ns/1ps
module pqs_port_qs_chk (
  // bus
  input wire       ref_clk,
  input wire       rst_n,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  // pads
  input wire [6:0] portQIn,
  input wire [6:0] portQOe,
  input wire [6:0] portQPullUp,
  input wire [6:0] portQPullDown,
  input wire [7:0] portSOe,
  input wire [7:0] portSPullUp,
  input wire [7:0] portSPullDown,
  input wire [3:0] pwmFault,
  input wire [2:0] pwmCurrentSenseN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_ready_prompt: assert property (psel && penable |-> pready)
    else $error("access not answered");
  chk_ready_only: assert property (pready |-> penable ##1 !pready)
    else $error("stray ready");
  chk_err_ready: assert property (pslverr |-> pready && psel)
    else $error("stray error");
  chk_q_pull_out: assert property ((portQOe & portQPullUp) == 0)
    else $error("pull on output");
  chk_q_pull_one: assert property ((portQPullUp & portQPullDown) == 0)
    else $error("q pulls both");
  chk_s_pull_one: assert property ((portSPullUp & portSPullDown) == 0)
    else $error("s pulls both");
  chk_rst_hiz: assert property ($rose(rst_n) |-> !portSOe && !portQOe)
    else $error("pin driven after reset");
  chk_pin_sync: assert property ($stable(portQIn) [*6] |->
    {pwmCurrentSenseN, pwmFault} == portQIn) else $error("fault input");
  cover property (pslverr);
  cover property (portQPullDown != 0);
  cover property (portSOe[3] && !portSOe[2]);
endmodule
bind pqs_port_qs pqs_port_qs_chk u_chk (.*);

// ===== verification/pqs_pin_model.sv
`timescale 1ns/1ps
module pqs_pin_model (
  // pads
  input  wire [6:0] portQOe,
  input  wire [6:0] portQOut,
  input  wire [7:0] portSOe,
  input  wire [7:0] portSOut,
  // outside drivers
  input  wire [6:0] extQ,
  input  wire [7:0] extS,
  output wire [6:0] portQIn,
  output wire [7:0] portSIn
);
  // released pins follow the outside driver
  assign portQIn = portQOe & portQOut | ~portQOe & extQ;
  assign portSIn = portSOe & portSOut | ~portSOe & extS;
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  portQIn, portQOut, portQOe, portQReduce, extQ;
  logic [6:0]  portQPullUp, portQPullDown;
  logic [7:0]  portSIn, portSOut, portSOe, portSReduce, extS, oe, m;
  logic [7:0]  portSPullUp, portSPullDown, v[13];
  logic [3:0]  pwmFault, spiOut, spiOe, spiIn;
  logic [2:0]  pwmCurrentSenseN;
  logic        secondSerialTransmit, secondSerialReceive, f;
  logic        firstSerialTransmit, firstSerialReceive;
  int          num_errors, cmp_count, cyc;
  pqs_port_qs   u_dut (.*);
  pqs_pin_model u_pin (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      num_errors++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, int i, logic [15:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(4 * i);
    pwdata <= {16'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(int i, logic [7:0] e, string nm);
    apb(1'b0, i, 0);
    cmp(nm, e, rd);
  endtask
  function automatic logic [7:0] pull(logic [7:0] en, act, pol);
    return en & act & pol;
  endfunction
  function automatic logic [7:0] msk(int i);
    return i < 5 ? 8'h7F : i == 7 ? 8'hF7 : 8'hFF;
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, extQ, extS} = '0;
    {spiOut, spiOe, secondSerialTransmit, firstSerialTransmit} = '0;
    m = 8'($urandom(33443));
    repeat (16) @(posedge ref_clk);
    cmp("reset oe", 0, {portQOe, portSOe});
    rst_n <= 1'b1;
    for (int i = 1; i < 13; i++) rc(i, 0, "reset value");
    rc(13, 0, "unmapped");
    cmp("slverr", 1, err);
    $display("reset test done");
    for (int k = 0; k < 12; k++) begin
      f = k % 3 == 2;
      foreach (v[i]) v[i] = 8'($urandom);
      if (f) v[11] = 0;
      extQ <= 7'($urandom);
      extS <= 8'($urandom);
      {spiOut, spiOe, secondSerialTransmit, firstSerialTransmit} <= 10'($urandom);
      for (int i = 0; i < 12; i++) apb(1'b1, i, v[i]);
      apb(1'b1, 12, {1'b0, v[12][6:0], 3'h0, {5{f}}});
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      oe = v[1] & ~v[12] & 8'h7F;
      cmp("q oe", oe, portQOe);
      cmp("q drive", v[2] & oe, portQReduce);
      cmp("q out", 0, portQOut);
      cmp("q up", pull(v[3] & 8'h7F, ~oe, ~v[4]), portQPullUp);
      cmp("q down", pull(v[3] & 8'h7F, ~oe, v[4]), portQPullDown);
      cmp("q fault", extQ & ~oe, {pwmCurrentSenseN, pwmFault});
      rc(0, extQ & ~oe, "q pins");
      for (int i = 1; i < 12; i++)
        if (i != 5 && i != 6) rc(i, v[i] & msk(i), "rdbk");
      m = v[7] & 8'hF7;
      if (!f) begin
        oe = m & ~(v[11] & v[5]);
        cmp("s oe", oe, portSOe);
        cmp("s drive", v[8] & oe, portSReduce);
        cmp("s out", oe & v[5], portSOut & portSOe);
        cmp("s up", pull(v[9], ~m | v[11], ~v[10]), portSPullUp);
        cmp("s down", pull(v[9], ~m | v[11], v[10]), portSPullDown);
        rc(5, v[5] & m | extS & ~m, "s data");
        rc(6, oe & v[5] | extS & ~oe, "s pins");
      end else begin
        cmp("f oe", {spiOe, 4'hA}, portSOe);
        cmp("f out", {spiOut & spiOe, secondSerialTransmit, 1'b0,
          firstSerialTransmit, 1'b0}, portSOut & portSOe);
        cmp("f in", {spiOe & spiOut | ~spiOe & extS[7:4], extS[2],
          extS[0]}, {spiIn, secondSerialReceive, firstSerialReceive});
      end
      $display("round %0d done", k);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp("reset oe", 0, {portQOe, portSOe});
    complete_run();
  end
endmodule
